// file: scc_pin_edge.sv
// pin synchroniser with rise and fall pulses
`timescale 1ns/100ps
module scc_pin_edge
  import scc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } scc_edge_state_t;

  scc_edge_state_t s_r;
  scc_edge_state_t s_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = i_pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // edges are seen between the settled stage and its delayed copy
  assign o_level = s_r.sync2;
  assign o_rise = s_r.sync2 & ~s_r.prev;
  assign o_fall = ~s_r.sync2 & s_r.prev;
endmodule // scc_pin_edge

// file: scc_pin_model.sv
// far side of the unit pin: an outside source with a release and a pull-up
`timescale 1ns/100ps
module scc_pin_model (
  input wire logic i_ext_drive,
  input wire logic i_ext_level,
  input wire logic i_unit_owned,
  input wire logic i_unit_level,
  output logic o_pad
);
  always_comb begin
    if (i_unit_owned) begin
      o_pad = i_unit_level;
    end else if (i_ext_drive) begin
      o_pad = i_ext_level;
    end else begin
      o_pad = 1'b1; // pull-up, so a released pad never floats
    end
  end
endmodule // scc_pin_model

// file: scc_pkg.sv
// constants, types and decode helpers for the capture/compare/pwm unit
package scc_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] SCC_OFF_CONTROL = 2'h0;
  localparam logic [1:0] SCC_OFF_DATA_LOW = 2'h1;
  localparam logic [1:0] SCC_OFF_DATA_HIGH = 2'h2;
  localparam logic [1:0] SCC_OFF_STATUS = 2'h3;
  // field positions in unit_control and status
  localparam int SCC_MODE_LSB = 0;
  localparam int SCC_DUTY_LSB = 4;
  localparam int SCC_FLAG_BIT = 0;
  localparam int SCC_PIN_BIT = 1;
  // values after reset
  localparam logic [3:0] SCC_MODE_RESET = 4'h0;
  localparam logic [1:0] SCC_DUTY_RESET = 2'h0;
  localparam logic [7:0] SCC_BYTE_RESET = 8'h00;
  localparam logic [3:0] SCC_PRESC_RESET = 4'h0;
  // mode codes
  localparam logic [3:0] SCC_MODE_OFF = 4'h0;
  localparam logic [3:0] SCC_MODE_TOGGLE = 4'h2;
  localparam logic [3:0] SCC_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] SCC_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] SCC_MODE_CAP_4TH = 4'h6;
  localparam logic [3:0] SCC_MODE_CAP_16TH = 4'h7;
  localparam logic [3:0] SCC_MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] SCC_MODE_SET_LOW = 4'h9;
  localparam logic [3:0] SCC_MODE_SOFT = 4'hA;
  // prescaler terminal counts and the zero duty value
  localparam logic [1:0] SCC_PRESC_4TH_LAST = 2'h3;
  localparam logic [3:0] SCC_PRESC_16TH_LAST = 4'hF;
  localparam logic [9:0] SCC_DUTY_ZERO = 10'h000;

  // capture modes are 01xx
  function automatic logic scc_is_capture(input logic [3:0] mode);
    return mode[3:2] == 2'h1;
  endfunction

  // compare modes: toggle plus 1000 to 1010
  function automatic logic scc_is_compare(input logic [3:0] mode);
    return (mode == SCC_MODE_TOGGLE) || (mode == SCC_MODE_SET_HIGH)
      || (mode == SCC_MODE_SET_LOW) || (mode == SCC_MODE_SOFT);
  endfunction

  // pwm modes are 11xx
  function automatic logic scc_is_pwm(input logic [3:0] mode);
    return mode[3:2] == 2'h3;
  endfunction
endpackage

// file: scc_unit.sv
// capture/compare/pwm unit with its host register file
// Behaviour
// - mode 0000 disables the unit and clears its pin latch and prescaler
// - mode 0010 toggles the pin on timer match and sets the flag
// - modes 0100..0111 capture on fall, rise, 4th rise, 16th rise
// - mode 1000 drives pin low on entry, high on match, sets flag
// - mode 1001 drives pin high on entry, low on match, sets flag
// - mode 1010 match only sets the flag; pin follows port latch
// - modes 11xx are pwm; duty is low data byte plus two duty bits
// - control bits 7 and 6 read as zero
// - duty bits unused outside pwm; control and data bytes read/write, high data byte read-only in pwm
// - capture copies the selected 16-bit timer into the data pair
// - capture sets the flag; only software clears it
// - a newer capture overwrites an unread older one
// - capture/compare use timer 1 or 3, pwm uses timer 2 or 4
// - prescaler clears when the unit is off or capture is left
// - switching between capture prescales keeps the prescaler count
// - host sets pin as input; a driven pin can still cause capture
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module scc_unit
  import scc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_pin,
  input wire logic i_capture_uses_timer_three,
  input wire logic i_pwm_uses_timer_four,
  input wire logic [15:0] i_timer_one_count,
  input wire logic [15:0] i_timer_three_count,
  input wire logic [7:0] i_timer_two_count,
  input wire logic [1:0] i_timer_two_phase,
  input wire logic i_timer_two_restart,
  input wire logic [7:0] i_timer_four_count,
  input wire logic [1:0] i_timer_four_phase,
  input wire logic i_timer_four_restart,
  output logic o_pin_level,
  output logic o_pin_owned,
  output logic o_unit_interrupt_flag
);
  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] duty_low;
    logic [7:0] data_low;
    logic [7:0] data_high;
    logic [1:0] duty_lat;
    logic flag;
    logic pin_latch;
    logic [3:0] presc;
    logic match_prev;
    logic [7:0] rdata;
  } scc_state_t;

  scc_state_t s_r;
  scc_state_t s_nxt;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic ctrl_wr;
  logic stat_wr;
  logic [3:0] new_mode;
  logic [15:0] cc_time;
  logic match_now;
  logic cmp_hit;
  logic cap_hit;
  logic [9:0] pwm_pos;
  logic pwm_restart;
  logic [9:0] duty_next;
  logic [9:0] duty_live;

  // driven pin captures; the pad is sampled even while the port drives it
  scc_pin_edge u_pin_edge (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_pin),
    .o_level(pin_level),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // register port decode
  assign ctrl_wr = i_wr && (i_addr == SCC_OFF_CONTROL);
  assign stat_wr = i_wr && (i_addr == SCC_OFF_STATUS);
  assign new_mode = i_wdata[SCC_MODE_LSB +: 4];

  assign cc_time = i_capture_uses_timer_three ? i_timer_three_count
    : i_timer_one_count;
  assign pwm_pos = i_pwm_uses_timer_four
    ? {i_timer_four_count, i_timer_four_phase}
    : {i_timer_two_count, i_timer_two_phase};
  assign pwm_restart = i_pwm_uses_timer_four ? i_timer_four_restart
    : i_timer_two_restart;

  assign duty_next = {s_r.data_low, s_r.duty_low};
  assign duty_live = {s_r.data_high, s_r.duty_lat};

  // compare fires once as the timer arrives at the data value
  assign match_now = cc_time == {s_r.data_high, s_r.data_low};
  assign cmp_hit = scc_is_compare(s_r.mode) && match_now && !s_r.match_prev;

  always_comb begin
    case (s_r.mode)
      SCC_MODE_CAP_FALL: cap_hit = pin_fall;
      SCC_MODE_CAP_RISE: cap_hit = pin_rise;
      SCC_MODE_CAP_4TH: cap_hit = pin_rise && (s_r.presc[1:0] == SCC_PRESC_4TH_LAST);
      SCC_MODE_CAP_16TH: cap_hit = pin_rise && (s_r.presc == SCC_PRESC_16TH_LAST);
      default: cap_hit = 1'b0;
    endcase
  end

  // next state: host writes, then hardware events, then mode entry
  always_comb begin
    s_nxt = s_r;
    s_nxt.match_prev = match_now;
    if (i_wr && (i_addr == SCC_OFF_DATA_LOW)) begin
      s_nxt.data_low = i_wdata;
    end
    // in pwm the high byte is the duty slave and only reloads on restart
    if (i_wr && (i_addr == SCC_OFF_DATA_HIGH) && !scc_is_pwm(s_r.mode)) begin
      s_nxt.data_high = i_wdata;
    end
    // software clears the flag by writing zero
    if (stat_wr && !i_wdata[SCC_FLAG_BIT]) begin
      s_nxt.flag = 1'b0;
    end
    // partial count kept; rises count across prescale switches
    if (scc_is_capture(s_r.mode) && pin_rise) begin
      s_nxt.presc = s_r.presc + 4'h1;
    end
    if (cap_hit) begin
      {s_nxt.data_high, s_nxt.data_low} = cc_time;
      s_nxt.flag = 1'b1;
    end
    // compare action on the pin latch
    if (cmp_hit) begin
      s_nxt.flag = 1'b1;
      case (s_r.mode)
        SCC_MODE_TOGGLE: s_nxt.pin_latch = !s_r.pin_latch;
        SCC_MODE_SET_HIGH: s_nxt.pin_latch = 1'b1;
        SCC_MODE_SET_LOW: s_nxt.pin_latch = 1'b0;
        default: s_nxt.pin_latch = s_r.pin_latch;
      endcase
    end
    if (scc_is_pwm(s_r.mode)) begin
      if (pwm_restart) begin
        s_nxt.data_high = s_r.data_low;
        s_nxt.duty_lat = s_r.duty_low;
        s_nxt.pin_latch = duty_next != SCC_DUTY_ZERO;
      end else if (pwm_pos == duty_live) begin
        s_nxt.pin_latch = 1'b0;
      end
    end
    if (ctrl_wr) begin
      s_nxt.mode = new_mode;
      s_nxt.duty_low = i_wdata[SCC_DUTY_LSB +: 2];
      if (!scc_is_capture(new_mode)) begin
        s_nxt.presc = SCC_PRESC_RESET;
      end
      if (new_mode != s_r.mode) begin
        case (new_mode)
          SCC_MODE_OFF: s_nxt.pin_latch = 1'b0;
          SCC_MODE_SET_HIGH: s_nxt.pin_latch = 1'b0;
          SCC_MODE_SET_LOW: s_nxt.pin_latch = 1'b1;
          default: s_nxt.pin_latch = s_nxt.pin_latch;
        endcase
      end
    end
    // read data stand in the cycle after the strobe
    s_nxt.rdata = SCC_BYTE_RESET;
    if (i_rd) begin
      case (i_addr)
        SCC_OFF_CONTROL: s_nxt.rdata = {2'h0, s_r.duty_low, s_r.mode};
        SCC_OFF_DATA_LOW: s_nxt.rdata = s_r.data_low;
        SCC_OFF_DATA_HIGH: s_nxt.rdata = s_r.data_high;
        default: s_nxt.rdata = {6'h00, pin_level, s_r.flag};
      endcase
    end
  end

  // whole state in one register
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_r.mode <= SCC_MODE_RESET;
      s_r.duty_low <= SCC_DUTY_RESET;
      s_r.data_low <= SCC_BYTE_RESET;
      s_r.data_high <= SCC_BYTE_RESET;
      s_r.duty_lat <= SCC_DUTY_RESET;
      s_r.flag <= 1'b0;
      s_r.pin_latch <= 1'b0;
      s_r.presc <= SCC_PRESC_RESET;
      s_r.match_prev <= 1'b0;
      s_r.rdata <= SCC_BYTE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs; 1010 and capture leave the pin to the port logic
  assign o_rdata = s_r.rdata;
  assign o_pin_level = s_r.pin_latch;
  assign o_unit_interrupt_flag = s_r.flag;
  assign o_pin_owned = (s_r.mode == SCC_MODE_TOGGLE)
    || (s_r.mode == SCC_MODE_SET_HIGH) || (s_r.mode == SCC_MODE_SET_LOW)
    || scc_is_pwm(s_r.mode);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  sequence s_write_off;
    ctrl_wr && (new_mode == SCC_MODE_OFF);
  endsequence

  sequence s_quiet_host;
    !i_wr;
  endsequence

  sequence s_sixteenth_rise;
    s_r.mode == SCC_MODE_CAP_16TH && s_r.presc == SCC_PRESC_16TH_LAST
      && pin_rise;
  endsequence

  a_off_clears: assert property (
    s_write_off |=> (s_r.presc == SCC_PRESC_RESET) && !o_pin_level
      && (s_r.mode == SCC_MODE_OFF))
    else $error("mode off did not clear the unit");

  a_toggle_match: assert property (
    cmp_hit && (s_r.mode == SCC_MODE_TOGGLE) && !i_wr
      |=> o_pin_level == !$past(o_pin_level) && o_unit_interrupt_flag)
    else $error("toggle on match missing");

  a_sixteenth_capture: assert property (
    s_sixteenth_rise ##0 s_quiet_host
      |=> {s_r.data_high, s_r.data_low} == $past(cc_time)
      && s_r.presc == SCC_PRESC_RESET)
    else $error("sixteenth edge capture wrong");

  a_set_high: assert property (
    ctrl_wr && new_mode == SCC_MODE_SET_HIGH && s_r.mode != SCC_MODE_SET_HIGH
      |=> !o_pin_level)
    else $error("set high entry wrong");

  a_force_low: assert property (
    cmp_hit && (s_r.mode == SCC_MODE_SET_LOW) && !i_wr
      |=> !o_pin_level && o_unit_interrupt_flag)
    else $error("force low on match missing");

  a_soft_only: assert property (
    s_r.mode == SCC_MODE_SOFT |-> !o_pin_owned)
    else $error("software mode drives pin");

  a_upper_zero: assert property (
    i_rd && (i_addr == SCC_OFF_CONTROL) |=> o_rdata[7:6] == 2'h0)
    else $error("control upper bits not zero");

  a_flag_sticky: assert property (
    o_unit_interrupt_flag && !stat_wr |=> o_unit_interrupt_flag)
    else $error("flag cleared without software");

  a_capture_loads: assert property (
    cap_hit |=> {s_r.data_high, s_r.data_low} == $past(cc_time)
      && o_unit_interrupt_flag)
    else $error("capture did not load timer");

  a_prescale_kept: assert property (
    ctrl_wr && scc_is_capture(s_r.mode) && scc_is_capture(new_mode)
      && !pin_rise |=> $stable(s_r.presc))
    else $error("prescaler cleared on switch");

  a_reserved_idle: assert property (
    (s_r.mode == 4'h1 || s_r.mode == 4'h3 || s_r.mode == 4'hB)
      ##0 s_quiet_host |=> $stable(o_pin_level) && $stable(o_unit_interrupt_flag))
    else $error("reserved mode had effect");

  sequence s_fall_seen;
    s_r.mode == SCC_MODE_CAP_FALL && pin_fall;
  endsequence

  a_fall_capture: assert property (
    s_fall_seen |=> {s_r.data_high, s_r.data_low} == $past(cc_time)
      && o_unit_interrupt_flag)
    else $error("falling edge capture wrong");

  a_fourth_capture: assert property (
    s_r.mode == SCC_MODE_CAP_4TH && s_r.presc[1:0] == SCC_PRESC_4TH_LAST && pin_rise
      |=> o_unit_interrupt_flag && s_r.presc[1:0] == 2'h0)
    else $error("fourth edge capture wrong");

  a_leave_clears: assert property (
    ctrl_wr && !scc_is_capture(new_mode) |=> s_r.presc == SCC_PRESC_RESET)
    else $error("prescaler kept after leaving capture");

  a_timer_three: assert property (
    cap_hit && i_capture_uses_timer_three
      |=> {s_r.data_high, s_r.data_low} == $past(i_timer_three_count))
    else $error("capture missed timer three");

  a_timer_one: assert property (
    cap_hit && !i_capture_uses_timer_three
      |=> {s_r.data_high, s_r.data_low} == $past(i_timer_one_count))
    else $error("capture missed timer one");

  a_data_write: assert property (
    i_wr && (i_addr == SCC_OFF_DATA_LOW) && !cap_hit |=> s_r.data_low == $past(i_wdata))
    else $error("data low byte not written");

  a_pwm_restart: assert property (
    scc_is_pwm(s_r.mode) && pwm_restart && !ctrl_wr
      |=> s_r.data_high == $past(s_r.data_low)
      && o_pin_level == ($past(s_r.data_low) != 8'h00 || $past(s_r.duty_low) != 2'h0))
    else $error("pwm restart did not latch duty");

  a_duty_end: assert property (
    scc_is_pwm(s_r.mode) && !pwm_restart && !ctrl_wr
      && pwm_pos == {s_r.data_high, s_r.duty_lat} |=> !o_pin_level)
    else $error("pwm pin not cleared at duty");

  a_high_locked: assert property (
    scc_is_pwm(s_r.mode) && i_wr && (i_addr == SCC_OFF_DATA_HIGH) && !pwm_restart
      |=> $stable(s_r.data_high))
    else $error("duty slave written by host");
endmodule // scc_unit

// file: scc_unit_tb.sv
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/100ps
module scc_unit_tb;
  import scc_pkg::*;
  typedef struct packed {logic [7:0] exp; logic [7:0] mask;} scc_note_t;
  localparam logic [1:0] CT = SCC_OFF_CONTROL;
  localparam logic [1:0] LO = SCC_OFF_DATA_LOW;
  localparam logic [1:0] HI = SCC_OFF_DATA_HIGH;
  localparam logic [1:0] ST = SCC_OFF_STATUS;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic sel3 = 1'b0;
  logic sel4 = 1'b0;
  logic [15:0] t1 = 16'h0000;
  logic [15:0] t3 = 16'h0000;
  logic [7:0] t2c = 8'h00;
  logic [7:0] t4c = 8'h00;
  logic [1:0] t2p = 2'h0;
  logic [1:0] t4p = 2'h0;
  logic t2r = 1'b0;
  logic t4r = 1'b0;
  logic ext_drive = 1'b1;
  logic ext_level = 1'b0;
  logic rd_pend = 1'b0;
  logic pad, pin_lvl, owned, flag, own, hit;
  logic [7:0] o_rdata, d;
  logic [2:0] snap = 3'h0;
  logic [1:0] dd;
  logic [3:0] m;
  logic [15:0] pair, cap_exp;
  logic [3:0] cap_m [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
  int cap_pre [4] = '{0, 0, 3, 15};
  logic [3:0] cmp_m [7] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'h1, 4'h3, 4'hB};
  scc_note_t notes [$];
  scc_note_t note;
  int seed = 15540;
  int bad_count = 0;
  int cmp_count = 0;

  scc_unit dut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(o_rdata), .i_pin(pad),
    .i_capture_uses_timer_three(sel3), .i_pwm_uses_timer_four(sel4),
    .i_timer_one_count(t1), .i_timer_three_count(t3), .i_timer_two_count(t2c),
    .i_timer_two_phase(t2p), .i_timer_two_restart(t2r), .i_timer_four_count(t4c),
    .i_timer_four_phase(t4p), .i_timer_four_restart(t4r), .o_pin_level(pin_lvl),
    .o_pin_owned(owned), .o_unit_interrupt_flag(flag));
  scc_pin_model pin_m (.i_ext_drive(ext_drive), .i_ext_level(ext_level),
    .i_unit_owned(owned), .i_unit_level(pin_lvl), .o_pad(pad));

  // 40 MHz clock
  always #12.5 i_clock = ~i_clock;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe, so pair them there
  always @(posedge i_clock) begin
    if (rd_pend) begin
      note = notes.pop_front();
      check("rdata", o_rdata & note.mask, note.exp);
    end
    rd_pend <= rd_s;
  end

  // pin outputs sampled mid-cycle, where they are settled
  always @(negedge i_clock) snap <= {owned, pin_lvl, flag};

  task automatic look(input logic o, input logic p, input logic f, input logic [2:0] k);
    check("pins", {5'h0, snap & k}, {5'h0, {o, p, f} & k});
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge i_clock);
    wr_s <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic reg_rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] k = 8'hFF);
    notes.push_back('{e, k});
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_clock);
    rd_s <= 1'b0;
    @(posedge i_clock);
  endtask

  // edges spaced well apart so the synchroniser sees each one
  task automatic pulse(input int n);
    repeat (n) begin
      ext_level <= 1'b1;
      repeat (4) @(posedge i_clock);
      ext_level <= 1'b0;
      repeat (5) @(posedge i_clock);
    end
  endtask

  // timers hold fresh random counts; cap_exp keeps the one sel3 picks
  task automatic tm_new;
    logic [15:0] a;
    logic [15:0] b;
    logic s;
    a = 16'($random(seed));
    b = 16'($random(seed));
    s = 1'($random(seed));
    t1 <= a;
    t3 <= b;
    sel3 <= s;
    cap_exp = s ? b : a;
  endtask

  task automatic cap_run(input logic [3:0] cm, input int pre, input bit clr);
    if (clr) reg_wr(CT, 8'h00);
    tm_new();
    reg_wr(CT, {4'h0, cm});
    reg_wr(ST, 8'h00);
    pulse(pre);
    reg_rd(ST, 8'h00, 8'h01);
    pulse(1);
    reg_rd(ST, 8'h01, 8'h01);
    reg_rd(LO, cap_exp[7:0]);
    reg_rd(HI, cap_exp[15:8]);
  endtask

  // hang guard, far beyond the fewer than a thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    for (int i = 0; i < 4; i++) reg_rd(2'(i), 8'h00);
    reg_wr(CT, 8'hF5);
    reg_rd(CT, 8'h35);
    reg_wr(LO, 8'hA5);
    reg_wr(HI, 8'h5A);
    reg_rd(LO, 8'hA5);
    reg_rd(HI, 8'h5A);
    for (int i = 0; i < 4; i++) cap_run(cap_m[i], cap_pre[i], 1'b1);
    reg_wr(CT, 8'h06);
    pulse(2);
    cap_run(4'h6, 3, 1'b1);
    reg_wr(CT, 8'h00);
    reg_wr(CT, 8'h07);
    pulse(2);
    cap_run(4'h6, 1, 1'b0);
    tm_new();
    pulse(4);
    tm_new();
    pulse(4);
    reg_rd(ST, 8'h01, 8'h01);
    reg_rd(LO, cap_exp[7:0]);
    reg_rd(HI, cap_exp[15:8]);
    ext_drive <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      m = cmp_m[i];
      own = (m == 4'h8) || (m == 4'h9) || (m == 4'h2);
      hit = own || (m == 4'hA);
      pair = 16'($random(seed));
      reg_wr(CT, 8'h00);
      reg_wr(LO, pair[7:0]);
      reg_wr(HI, pair[15:8]);
      t1 <= ~pair;
      t3 <= ~pair;
      sel3 <= 1'($random(seed));
      reg_wr(CT, {2'h0, 2'($random(seed)), m});
      reg_wr(ST, 8'h00);
      look(own, m == 4'h9, 1'b0, {1'b1, own, 1'b1});
      if (sel3) t3 <= pair; else t1 <= pair;
      repeat (3) @(posedge i_clock);
      look(own, m != 4'h9, hit, {1'b1, own, 1'b1});
      repeat (4) @(posedge i_clock);
      look(own, m != 4'h9, hit, {1'b1, own, 1'b1});
      reg_wr(ST, 8'h00);
      repeat (2) @(posedge i_clock);
      look(own, 1'b0, 1'b0, 3'h1);
      if (m == 4'h2) begin
        t1 <= ~pair;
        t3 <= ~pair;
        @(posedge i_clock);
        if (sel3) t3 <= pair; else t1 <= pair;
        repeat (3) @(posedge i_clock);
        look(1'b1, 1'b0, 1'b1, 3'h7);
      end
    end
    for (int i = 0; i < 5; i++) begin
      d = (i < 4) ? (8'($random(seed)) | 8'h01) : 8'h00;
      dd = (i < 4) ? 2'($random(seed)) : 2'h0;
      reg_wr(CT, 8'h00);
      sel4 <= 1'($random(seed));
      {t2c, t2p, t4c, t4p} <= 20'h00000;
      reg_wr(LO, d);
      reg_wr(CT, {2'h0, dd, 2'h3, 2'(i)});
      reg_wr(HI, ~d);
      if (sel4) t4r <= 1'b1; else t2r <= 1'b1;
      @(posedge i_clock);
      t4r <= 1'b0;
      t2r <= 1'b0;
      repeat (2) @(posedge i_clock);
      look(1'b1, i < 4, 1'b0, 3'h6);
      reg_rd(HI, d);
      if (sel4) {t4c, t4p} <= {d, dd}; else {t2c, t2p} <= {d, dd};
      repeat (3) @(posedge i_clock);
      look(1'b1, 1'b0, 1'b0, 3'h6);
    end
    reg_wr(CT, 8'h00);
    repeat (2) @(posedge i_clock);
    look(1'b0, 1'b0, 1'b0, 3'h6);
    conclude();
  end
endmodule // scc_unit_tb
